// file: verilog/mpa_defines.svh
/*
 Constants for the multifunction pin allocator: selection codes and reset values.
 Assumes inclusion by its bare name from the package and the design file.
*/
`ifndef MPA_DEFINES_SVH
`define MPA_DEFINES_SVH

// ----------------------------------------
// Codec reference clock select codes
// ----------------------------------------
`define MPA_CODEC_SEL_W      2
`define MPA_CODEC_SEL_MCLK   2'h0
`define MPA_CODEC_SEL_BCLK   2'h1
`define MPA_CODEC_SEL_GPIO   2'h2
`define MPA_CODEC_SEL_PLL    2'h3
`define MPA_CODEC_SEL_RST    2'h0

// ----------------------------------------
// PLL reference select codes
// ----------------------------------------
`define MPA_PLL_SEL_W        2
`define MPA_PLL_SEL_MCLK     2'h0
`define MPA_PLL_SEL_BCLK     2'h1
`define MPA_PLL_SEL_GPIO     2'h2
`define MPA_PLL_SEL_DIN      2'h3
`define MPA_PLL_SEL_RST      2'h0

// ----------------------------------------
// Pin function codes
// ----------------------------------------
`define MPA_FN_W             4
`define MPA_FN_OFF           4'h0
`define MPA_FN_IN            4'h1
`define MPA_FN_GPO           4'h2
`define MPA_FN_FIRST_INTERRUPT_OUTPUT          4'h3
`define MPA_FN_SECOND_INTERRUPT_OUTPUT          4'h4
`define MPA_FN_SEC_BCLK_OUT  4'h5
`define MPA_FN_SEC_WCLK_OUT  4'h6
`define MPA_FN_SEC_DOUT      4'h7
`define MPA_FN_AUX_CLK       4'h8
`define MPA_FN_CLK_IN        4'h9
`define MPA_FN_SEC_BCLK_IN   4'ha
`define MPA_FN_SEC_WCLK_IN   4'hb
`define MPA_FN_SEC_DIN       4'hc
`define MPA_FN_PRI_OUT       4'hd
`define MPA_FN_RST           4'h0

`endif

// file: verilog/mpa_pkg.sv
/*
 Types of the multifunction pin allocator.
 Assumes mpa_defines.svh is on the include path.
*/
`include "mpa_defines.svh"

package mpa_pkg;

	// ----------------------------------------
	// Function selection per pin
	// ----------------------------------------
	typedef logic [`MPA_FN_W-1:0] mpa_fn_type;

	typedef struct packed {
		logic [`MPA_CODEC_SEL_W-1:0] codec_sel;
		logic [`MPA_PLL_SEL_W-1:0]   pll_sel;
		logic                        bclk_out;
		logic                        wclk_out;
		mpa_fn_type                  gpio_fn;
		mpa_fn_type                  sclk_fn;
		mpa_fn_type                  miso_fn;
	} mpa_cfg_type;

	// ----------------------------------------
	// Sources that may land on a pin or, for pll_out, on the codec clock
	// ----------------------------------------
	typedef struct packed {
		logic pri_bclk;
		logic pri_wclk;
		logic gpo1;
		logic gpo2;
		logic first_interrupt_output;
		logic second_interrupt_output;
		logic sec_bclk;
		logic sec_wclk;
		logic sec_dout;
		logic aux_clk;
		logic pll_out;
	} mpa_src_type;

	// ----------------------------------------
	// Signals handed to the core
	// ----------------------------------------
	typedef struct packed {
		logic pll_ref;
		logic codec_reference_clock;
		logic pri_bclk_in;
		logic pri_wclk_in;
		logic pri_din;
		logic gpi1;
		logic gpi2;
		logic gpi3;
		logic sec_bclk_in;
		logic sec_wclk_in;
		logic sec_din;
	} mpa_core_type;

	// ----------------------------------------
	// Pad drive, five pins, sclk never driven
	// ----------------------------------------
	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe_n;
	} mpa_pad_type;

	typedef struct packed {
		mpa_core_type core;
		mpa_pad_type  pad;
		logic         cfg_err;
	} mpa_state_type;

endpackage : mpa_pkg

// file: verilog/mpa_pin_allocator.sv
/*
 Multifunction pin allocator: routes the audio amplifier's digital pins to
 clock, audio serial, general-purpose, interrupt and aux clock functions.
 Assumes pins and configuration are synchronous to core_clk; configuration
 comes from the device register file outside this block.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mpa_defines.svh"

// Behaviour
// - The master clock pin may feed the PLL reference and the codec clock together, and is the codec clock by default.
// - The bit clock pin may feed the PLL reference, the codec clock and the serial bit clock input together, and is that bit clock input by default.
// - The general-purpose pin may feed the PLL reference and the codec clock together when chosen as a clock source.
// - A pin given an exclusive function has its core inputs held low; PLL and codec selects of bclk or gpio still take the pin.
// - The PLL reference comes from one of the master clock, bit clock, data-in or general-purpose pins.
// - A two-bit field picks the codec reference clock source.
module mpa_pin_allocator (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	// Configuration
	input  wire mpa_pkg::mpa_cfg_type cfg,
	// Pin inputs: mclk, bclk, wclk, din, gpio, sclk, miso
	input  wire logic [6:0]           pin_in,
	// Internal sources
	input  wire mpa_pkg::mpa_src_type src,
	// Core side
	output var mpa_pkg::mpa_core_type core,
	// Pads: bclk, wclk, gpio, miso, sclk
	output logic [4:0]                pad_out,
	output logic [4:0]                pad_oe_n,
	// Illegal allocation seen
	output logic                      cfg_err
);

	localparam int P_MCLK = 0;
	localparam int P_BCLK = 1;
	localparam int P_WCLK = 2;
	localparam int P_DIN  = 3;
	localparam int P_GPIO = 4;
	localparam int P_SCLK = 5;
	localparam int P_MISO = 6;

	mpa_pkg::mpa_state_type state_reg;
	mpa_pkg::mpa_state_type state_next;

	// ----------------------------------------
	// Output source of one function code
	// ----------------------------------------
	function automatic logic [1:0] fn_drive(input mpa_pkg::mpa_fn_type fn, input mpa_pkg::mpa_src_type s);
		logic [1:0] r;
		r = 2'h0;
		case (fn)
			`MPA_FN_GPO:          r = 2'h3;
			`MPA_FN_FIRST_INTERRUPT_OUTPUT:         r = {1'b1, s.first_interrupt_output};
			`MPA_FN_SECOND_INTERRUPT_OUTPUT:         r = {1'b1, s.second_interrupt_output};
			`MPA_FN_SEC_BCLK_OUT: r = {1'b1, s.sec_bclk};
			`MPA_FN_SEC_WCLK_OUT: r = {1'b1, s.sec_wclk};
			`MPA_FN_SEC_DOUT:     r = {1'b1, s.sec_dout};
			`MPA_FN_AUX_CLK:      r = {1'b1, s.aux_clk};
			default:              r = 2'h0;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// Functions the gpio pin may carry
	// ----------------------------------------
	function automatic logic gpio_allowed(input mpa_pkg::mpa_fn_type fn);
		logic ok;
		ok = 1'b0;
		case (fn)
			`MPA_FN_OFF:          ok = 1'b1;
			`MPA_FN_IN:           ok = 1'b1;
			`MPA_FN_GPO:          ok = 1'b1;
			`MPA_FN_FIRST_INTERRUPT_OUTPUT:         ok = 1'b1;
			`MPA_FN_SECOND_INTERRUPT_OUTPUT:         ok = 1'b1;
			`MPA_FN_SEC_BCLK_IN:  ok = 1'b1;
			`MPA_FN_SEC_WCLK_IN:  ok = 1'b1;
			`MPA_FN_SEC_DIN:      ok = 1'b1;
			`MPA_FN_SEC_BCLK_OUT: ok = 1'b1;
			`MPA_FN_SEC_WCLK_OUT: ok = 1'b1;
			`MPA_FN_AUX_CLK:      ok = 1'b1;
			default:              ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Functions the miso pin may carry
	function automatic logic miso_allowed(input mpa_pkg::mpa_fn_type fn);
		logic ok;
		ok = 1'b0;
		case (fn)
			`MPA_FN_OFF:          ok = 1'b1;
			`MPA_FN_GPO:          ok = 1'b1;
			`MPA_FN_FIRST_INTERRUPT_OUTPUT:         ok = 1'b1;
			`MPA_FN_SECOND_INTERRUPT_OUTPUT:         ok = 1'b1;
			`MPA_FN_SEC_BCLK_OUT: ok = 1'b1;
			`MPA_FN_SEC_WCLK_OUT: ok = 1'b1;
			`MPA_FN_SEC_DOUT:     ok = 1'b1;
			`MPA_FN_AUX_CLK:      ok = 1'b1;
			default:              ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Functions the sclk pin may carry
	function automatic logic sclk_allowed(input mpa_pkg::mpa_fn_type fn);
		logic ok;
		ok = 1'b0;
		case (fn)
			`MPA_FN_OFF:         ok = 1'b1;
			`MPA_FN_IN:          ok = 1'b1;
			`MPA_FN_SEC_BCLK_IN: ok = 1'b1;
			`MPA_FN_SEC_WCLK_IN: ok = 1'b1;
			`MPA_FN_SEC_DIN:     ok = 1'b1;
			default:             ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ----------------------------------------
	// Input taken from gpio or sclk
	// ----------------------------------------
	function automatic logic fn_take(input mpa_pkg::mpa_cfg_type c, input mpa_pkg::mpa_fn_type code,
		input logic gpio_pin, input logic sclk_pin);
		logic v;
		v = 1'b0;
		if (c.gpio_fn == code)
			v = gpio_pin;
		else if (c.sclk_fn == code)
			v = sclk_pin;
		return v;
	endfunction

	// ----------------------------------------
	// Routing
	// ----------------------------------------
	always_comb begin
		logic [1:0] d;
		logic [1:0] gpo_sel;
		d = 2'h0;
		gpo_sel = 2'h0;
		state_next = state_reg;
		state_next.cfg_err = 1'b0;

		case (cfg.pll_sel)
			`MPA_PLL_SEL_MCLK: state_next.core.pll_ref = pin_in[P_MCLK];
			`MPA_PLL_SEL_BCLK: state_next.core.pll_ref = pin_in[P_BCLK];
			`MPA_PLL_SEL_GPIO: state_next.core.pll_ref = pin_in[P_GPIO];
			`MPA_PLL_SEL_DIN:  state_next.core.pll_ref = pin_in[P_DIN];
			default:           state_next.core.pll_ref = 1'b0;
		endcase

		case (cfg.codec_sel)
			`MPA_CODEC_SEL_MCLK: state_next.core.codec_reference_clock = pin_in[P_MCLK];
			`MPA_CODEC_SEL_BCLK: state_next.core.codec_reference_clock = pin_in[P_BCLK];
			`MPA_CODEC_SEL_GPIO: state_next.core.codec_reference_clock = pin_in[P_GPIO];
			`MPA_CODEC_SEL_PLL:  state_next.core.codec_reference_clock = src.pll_out;
			default:             state_next.core.codec_reference_clock = 1'b0;
		endcase

		state_next.core.pri_bclk_in = cfg.bclk_out ? 1'b0 : pin_in[P_BCLK];
		state_next.core.pri_wclk_in = cfg.wclk_out ? 1'b0 : pin_in[P_WCLK];
		state_next.core.pri_din = (cfg.pll_sel == `MPA_PLL_SEL_DIN) ? 1'b0 : pin_in[P_DIN];
		state_next.core.gpi1 = (cfg.pll_sel == `MPA_PLL_SEL_DIN) ? 1'b0 : pin_in[P_DIN];
		state_next.core.gpi2 = (cfg.gpio_fn == `MPA_FN_IN) ? pin_in[P_GPIO] : 1'b0;
		state_next.core.gpi3 = (cfg.sclk_fn == `MPA_FN_IN) ? pin_in[P_SCLK] : 1'b0;
		state_next.core.sec_bclk_in = fn_take(cfg, `MPA_FN_SEC_BCLK_IN, pin_in[P_GPIO], pin_in[P_SCLK]);
		state_next.core.sec_wclk_in = fn_take(cfg, `MPA_FN_SEC_WCLK_IN, pin_in[P_GPIO], pin_in[P_SCLK]);
		state_next.core.sec_din = fn_take(cfg, `MPA_FN_SEC_DIN, pin_in[P_GPIO], pin_in[P_SCLK]);

		state_next.pad.out[0] = cfg.bclk_out & src.pri_bclk;
		state_next.pad.oe_n[0] = ~cfg.bclk_out;
		state_next.pad.out[1] = cfg.wclk_out & src.pri_wclk;
		state_next.pad.oe_n[1] = ~cfg.wclk_out;

		d = fn_drive(cfg.gpio_fn, src);
		if (!gpio_allowed(cfg.gpio_fn))
			d = 2'h0;
		gpo_sel = {1'b0, src.gpo1};
		state_next.pad.out[2] = (cfg.gpio_fn == `MPA_FN_GPO) ? gpo_sel[0] : d[0];
		state_next.pad.oe_n[2] = ~d[1];
		d = fn_drive(cfg.miso_fn, src);
		gpo_sel = {1'b0, src.gpo2};
		state_next.pad.out[3] = (cfg.miso_fn == `MPA_FN_GPO) ? gpo_sel[0] : d[0];
		state_next.pad.oe_n[3] = ~d[1];
		// Sclk is input only
		state_next.pad.out[4] = 1'b0;
		state_next.pad.oe_n[4] = 1'b1;

		if (!gpio_allowed(cfg.gpio_fn) || !miso_allowed(cfg.miso_fn) || !sclk_allowed(cfg.sclk_fn) ||
			((cfg.codec_sel == `MPA_CODEC_SEL_GPIO || cfg.pll_sel == `MPA_PLL_SEL_GPIO) &&
			cfg.gpio_fn != `MPA_FN_OFF)) begin
			state_next.cfg_err = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.pad.oe_n <= 5'h1f;
		end else begin
			state_reg <= state_next;
		end
	end

	assign core = state_reg.core;
	assign pad_out = state_reg.pad.out;
	assign pad_oe_n = state_reg.pad.oe_n;
	assign cfg_err = state_reg.cfg_err;

endmodule // mpa_pin_allocator
`default_nettype wire

// file: dv/mpa_sva.sv
/*
 Checker for the pin allocator.
 Assumes a bind onto mpa_pin_allocator.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mpa_defines.svh"
module mpa_sva (
	// Clock and reset
	input wire logic                  core_clk,
	input wire logic                  rstn,
	// Inputs
	input wire mpa_pkg::mpa_cfg_type  cfg,
	input wire logic [6:0]            pin_in,
	input wire mpa_pkg::mpa_src_type  src,
	// Outputs
	input wire mpa_pkg::mpa_core_type core,
	input wire logic [4:0]            pad_out,
	input wire logic [4:0]            pad_oe_n,
	input wire logic                  cfg_err
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ------------------------------
	// Routing
	// ------------------------------
	chk_codec_mclk: assert property (cfg.codec_sel == `MPA_CODEC_SEL_MCLK |=>
		core.codec_reference_clock == $past(pin_in[0])) else $error("codec not mclk");
	chk_codec_bclk: assert property (cfg.codec_sel == `MPA_CODEC_SEL_BCLK |=>
		core.codec_reference_clock == $past(pin_in[1])) else $error("codec not bclk");
	chk_codec_gpio: assert property (cfg.codec_sel == `MPA_CODEC_SEL_GPIO && cfg.gpio_fn == `MPA_FN_OFF |=>
		core.codec_reference_clock == $past(pin_in[4])) else $error("codec not gpio");
	chk_pll_din: assert property (cfg.pll_sel == `MPA_PLL_SEL_DIN |=>
		core.pll_ref == $past(pin_in[3])) else $error("pll not din");
	chk_bclk_share: assert property (cfg.pll_sel == `MPA_PLL_SEL_BCLK && !cfg.bclk_out |=>
		core.pll_ref == $past(pin_in[1]) && core.pri_bclk_in == $past(pin_in[1])) else $error("bclk not shared");
	chk_gpio_first_interrupt_output: assert property (cfg.gpio_fn == `MPA_FN_FIRST_INTERRUPT_OUTPUT ##1 1 |->
		!pad_oe_n[2] && pad_out[2] == $past(src.first_interrupt_output)) else $error("gpio not first_interrupt_output");
	chk_excl_err: assert property (cfg.gpio_fn == `MPA_FN_SEC_DOUT |=> cfg_err && pad_oe_n[2])
		else $error("dout on gpio taken");
	chk_sclk_quiet: assert property (pad_oe_n[4]) else $error("sclk driven");
	cover property (cfg.gpio_fn == `MPA_FN_FIRST_INTERRUPT_OUTPUT ##1 !pad_oe_n[2]);
	cover property (cfg_err);
	cover property (cfg.bclk_out ##1 !pad_oe_n[0]);
endmodule // mpa_sva
bind mpa_pin_allocator mpa_sva mpa_sva_inst (.core_clk, .rstn, .cfg, .pin_in, .src, .core, .pad_out,
	.pad_oe_n, .cfg_err);
`default_nettype wire

// file: dv/tb.sv
/*
 Self-checking bench for the pin allocator.
 Assumes the checker binds itself.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mpa_defines.svh"
module tb;
	logic                  core_clk = 1'b0;
	logic                  rstn = 1'b0;
	mpa_pkg::mpa_cfg_type  cfg = '0;
	logic [6:0]            pin_in = 7'h03;
	mpa_pkg::mpa_src_type  src = '0;
	mpa_pkg::mpa_core_type core;
	logic [4:0]            pad_out;
	logic [4:0]            pad_oe_n;
	logic                  cfg_err;
	int                    miscompares = 0;
	int                    n_compared = 0;
	mpa_pkg::mpa_fn_type   gt [11] = '{`MPA_FN_OFF, `MPA_FN_IN, `MPA_FN_GPO, `MPA_FN_FIRST_INTERRUPT_OUTPUT, `MPA_FN_SECOND_INTERRUPT_OUTPUT,
		`MPA_FN_SEC_BCLK_OUT, `MPA_FN_SEC_WCLK_OUT, `MPA_FN_AUX_CLK, `MPA_FN_SEC_BCLK_IN, `MPA_FN_SEC_WCLK_IN,
		`MPA_FN_SEC_DIN};
	mpa_pkg::mpa_fn_type   st [5] = '{`MPA_FN_OFF, `MPA_FN_IN, `MPA_FN_SEC_BCLK_IN, `MPA_FN_SEC_WCLK_IN,
		`MPA_FN_SEC_DIN};
	mpa_pkg::mpa_fn_type   mt [8] = '{`MPA_FN_OFF, `MPA_FN_SEC_DOUT, `MPA_FN_GPO, `MPA_FN_FIRST_INTERRUPT_OUTPUT, `MPA_FN_SECOND_INTERRUPT_OUTPUT,
		`MPA_FN_SEC_BCLK_OUT, `MPA_FN_SEC_WCLK_OUT, `MPA_FN_AUX_CLK};
	always #5 core_clk = ~core_clk;
	mpa_pin_allocator mpa_pin_allocator_inst (.core_clk, .rstn, .cfg, .pin_in, .src, .core, .pad_out,
		.pad_oe_n, .cfg_err);
	// ------------------------------
	// Expectations and compare
	// ------------------------------
	function automatic logic [1:0] drv(input mpa_pkg::mpa_fn_type fn, input logic gpo);
		case (fn)
			`MPA_FN_GPO: return {1'b0, gpo};
			`MPA_FN_FIRST_INTERRUPT_OUTPUT: return {1'b0, src.first_interrupt_output};
			`MPA_FN_SECOND_INTERRUPT_OUTPUT: return {1'b0, src.second_interrupt_output};
			`MPA_FN_SEC_BCLK_OUT: return {1'b0, src.sec_bclk};
			`MPA_FN_SEC_WCLK_OUT: return {1'b0, src.sec_wclk};
			`MPA_FN_SEC_DOUT: return {1'b0, src.sec_dout};
			`MPA_FN_AUX_CLK: return {1'b0, src.aux_clk};
			default: return 2'b10;
		endcase
	endfunction
	function automatic logic pick(input logic [1:0] s, input logic l);
		return s == 2'h0 ? pin_in[0] : s == 2'h1 ? pin_in[1] : s == 2'h2 ? pin_in[4] : l;
	endfunction
	function automatic logic take(input mpa_pkg::mpa_fn_type code);
		return cfg.gpio_fn == code ? pin_in[4] : cfg.sclk_fn == code ? pin_in[5] : 1'b0;
	endfunction
	task automatic cmp(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic check_all();
		logic [1:0] g;
		logic [1:0] m;
		g = drv(cfg.gpio_fn, src.gpo1);
		m = drv(cfg.miso_fn, src.gpo2);
		cmp("codec", pick(cfg.codec_sel, src.pll_out), core.codec_reference_clock);
		cmp("pll", pick(cfg.pll_sel, pin_in[3]), core.pll_ref);
		cmp("bclk_oe", !cfg.bclk_out, pad_oe_n[0]);
		if (cfg.bclk_out)
			cmp("bclk_out", src.pri_bclk, pad_out[0]);
		else
			cmp("bclk_in", pin_in[1], core.pri_bclk_in);
		cmp("wclk_oe", !cfg.wclk_out, pad_oe_n[1]);
		if (cfg.wclk_out)
			cmp("wclk_out", src.pri_wclk, pad_out[1]);
		else
			cmp("wclk_in", pin_in[2], core.pri_wclk_in);
		cmp("din", cfg.pll_sel == `MPA_PLL_SEL_DIN ? 1'b0 : pin_in[3], core.pri_din);
		cmp("gpi1", cfg.pll_sel == `MPA_PLL_SEL_DIN ? 1'b0 : pin_in[3], core.gpi1);
		cmp("gpi2", cfg.gpio_fn == `MPA_FN_IN ? pin_in[4] : 1'b0, core.gpi2);
		cmp("gpi3", cfg.sclk_fn == `MPA_FN_IN ? pin_in[5] : 1'b0, core.gpi3);
		cmp("sec_bclk_in", take(`MPA_FN_SEC_BCLK_IN), core.sec_bclk_in);
		cmp("sec_wclk_in", take(`MPA_FN_SEC_WCLK_IN), core.sec_wclk_in);
		cmp("sec_din", take(`MPA_FN_SEC_DIN), core.sec_din);
		cmp("gpio_oe", g[1], pad_oe_n[2]);
		if (!g[1])
			cmp("gpio_out", g[0], pad_out[2]);
		cmp("miso_oe", m[1], pad_oe_n[3]);
		if (!m[1])
			cmp("miso_out", m[0], pad_out[3]);
		cmp("sclk_oe", 1'b1, pad_oe_n[4]);
		cmp("err", 1'b0, cfg_err);
	endtask
	task automatic check_reset();
		cmp("rst_oe", 1'b1, &pad_oe_n);
		cmp("rst_core", 1'b0, |{core, pad_out, cfg_err});
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ------------------------------
	// Tests
	// ------------------------------
	initial begin
		void'($urandom(39));
		repeat (3) @(negedge core_clk);
		check_reset();
		rstn = 1'b1;
		@(negedge core_clk);
		check_all();
		$display("test defaults done");
		repeat (400) begin
			cfg.gpio_fn = gt[$urandom_range(10)];
			cfg.miso_fn = mt[$urandom_range(7)];
			cfg.sclk_fn = st[$urandom_range(4)];
			if (cfg.sclk_fn == cfg.gpio_fn && cfg.sclk_fn != `MPA_FN_IN)
				cfg.sclk_fn = `MPA_FN_OFF;
			{cfg.codec_sel, cfg.pll_sel, cfg.wclk_out} = 5'($urandom);
			if (cfg.gpio_fn != `MPA_FN_OFF && cfg.codec_sel == `MPA_CODEC_SEL_GPIO)
				cfg.codec_sel = `MPA_CODEC_SEL_MCLK;
			if (cfg.gpio_fn != `MPA_FN_OFF && cfg.pll_sel == `MPA_PLL_SEL_GPIO)
				cfg.pll_sel = `MPA_PLL_SEL_DIN;
			cfg.bclk_out = cfg.codec_sel != `MPA_CODEC_SEL_BCLK && cfg.pll_sel != `MPA_PLL_SEL_BCLK && 1'($urandom);
			{src, pin_in} = 18'($urandom);
			@(negedge core_clk);
			check_all();
		end
		$display("test random done");
		for (int i = 0; i < 3; i++) begin
			cfg = '0;
			if (i == 0)
				cfg.gpio_fn = `MPA_FN_SEC_DOUT;
			if (i == 1)
				cfg.sclk_fn = `MPA_FN_AUX_CLK;
			if (i == 2)
				{cfg.gpio_fn, cfg.codec_sel} = {`MPA_FN_GPO, `MPA_CODEC_SEL_GPIO};
			@(negedge core_clk);
			cmp("bad_err", 1'b1, cfg_err);
			if (i < 2)
				cmp("bad_oe", 1'b1, pad_oe_n[i * 2 + 2]);
		end
		$display("test refusals done");
		rstn = 1'b0;
		cfg = '0;
		@(negedge core_clk);
		check_reset();
		rstn = 1'b1;
		@(negedge core_clk);
		check_all();
		$display("test reset done");
		results();
	end
	initial begin
		#50000;
		miscompares++;
		results();
	end
endmodule // tb
`default_nettype wire
